// >>> verilog/ima_microport.v
// indirect microport access: external byte registers and internal access sequencer
`timescale 1ns/10ps
`include "ima_defs.vh"
module ima_microport #(
   parameter DATA_W = 20
) (
   // clock and reset
   input  wire              CLK_I,
   input  wire              RESETN_I,
   // host byte bus
   input  wire              CS_N_I,
   input  wire              RD_N_I,
   input  wire              WR_N_I,
   input  wire              MODE_I,
   input  wire [2:0]        A_I,
   input  wire [7:0]        D_I,
   output wire [7:0]        D_O,
   output wire              D_OE_O,
   output wire              ACK_N_O,
   // internal register space
   output wire [9:0]        INT_ADDR_O,
   output wire [5:0]        INT_CHAN_O,
   output wire              INT_MAP_O,
   output wire [DATA_W-1:0] INT_WDATA_O,
   output wire              INT_WR_O,
   output wire              INT_RD_O,
   input  wire [DATA_W-1:0] INT_RDATA_I,
   input  wire              INT_DONE_I
);

   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_WAIT = 2'h1;
   localparam [1:0] ST_HOLD = 2'h2;

   wire       active;
   wire       is_write;
   reg  [1:0] state_q;
   reg  [1:0] state_d;
   reg  [7:0] data_low_q;
   reg  [7:0] data_mid_q;
   reg  [7:0] data_high_q;
   reg  [7:0] map_sel_q;
   reg  [7:0] chan_addr_q;
   reg  [7:0] acc_ctrl_q;
   reg  [7:0] dout_q;
   reg        doe_q;
   reg        ack_n_q;
   reg        int_wr_q;
   reg        int_rd_q;
   reg        rd_pend_q;
   wire       start;
   wire       store;
   wire       fetch;
   wire       finish;

   // strobe decode for the selected convention
   ima_strobe_decode u_dec (
      .cs_n_i     (CS_N_I),
      .rd_n_i     (RD_N_I),
      .wr_n_i     (WR_N_I),
      .mode_i     (MODE_I),
      .active_o   (active),
      .is_write_o (is_write)
   );

   // ------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------
   // an access is taken only from idle, so a strobe held through a long
   // internal cycle can never start a second access; the host must let the
   // strobe go for at least one edge before the next one is seen
   assign start  = (state_q == ST_IDLE) & active;
   assign store  = start & is_write;
   assign fetch  = start & ~is_write;
   // the internal cycle ends on the edge where the sequencer leaves the wait state;
   // accesses that do not touch the internal space finish one edge after the start
   assign finish = (state_q == ST_WAIT) & (state_d == ST_HOLD);

   // ------------------------------------------------------------
   // access sequencer
   // ------------------------------------------------------------
   // next state: start on strobe, wait for internal cycle, hold until strobe ends
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (active) begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!(int_wr_q | rd_pend_q) || INT_DONE_I) begin
               state_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!active) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // state register
   always @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------
   // external byte registers
   // ------------------------------------------------------------
   // host stores land on the start edge; an internal read refills the data bytes
   always @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         data_low_q  <= `IMA_REG_RESET;
         data_mid_q  <= `IMA_REG_RESET;
         data_high_q <= `IMA_REG_RESET;
         map_sel_q   <= `IMA_REG_RESET;
         chan_addr_q <= `IMA_REG_RESET;
         acc_ctrl_q  <= `IMA_REG_RESET;
      end else if (store) begin
         // stores hold until the next store to the same register or, for the data bytes, an internal read
         case (A_I)
            `IMA_OFS_DATA_LOW:  data_low_q  <= D_I;
            `IMA_OFS_DATA_MID:  data_mid_q  <= D_I;
            `IMA_OFS_DATA_HIGH: data_high_q <= D_I;
            `IMA_OFS_MAP_SEL:   map_sel_q   <= D_I;
            `IMA_OFS_CHAN_ADDR: chan_addr_q <= D_I;
            `IMA_OFS_ACC_CTRL:  acc_ctrl_q  <= D_I;
            default: ;
         endcase
      end else if (finish && rd_pend_q) begin
         // fill all three data bytes from the internal location; the unused top
         // nibble of the high byte reads as zero
         data_low_q  <= INT_RDATA_I[7:0];
         data_mid_q  <= INT_RDATA_I[15:8];
         data_high_q <= {4'h0, INT_RDATA_I[DATA_W-1:16]};
      end
   end

   // ------------------------------------------------------------
   // internal request strobes
   // ------------------------------------------------------------
   // the write request is a level held until completion, as the internal space
   // may take any number of cycles; the read request is one pulse, and a pending
   // flag remembers that its answer must be captured on the completion edge
   always @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         int_wr_q  <= 1'b0;
         int_rd_q  <= 1'b0;
         rd_pend_q <= 1'b0;
      end else begin
         int_rd_q <= 1'b0;
         if (store && A_I == `IMA_OFS_DATA_LOW) begin
            int_wr_q <= 1'b1;
         end else if (fetch && A_I == `IMA_OFS_DATA_LOW) begin
            int_rd_q  <= 1'b1;
            rd_pend_q <= 1'b1;
         end else if (finish) begin
            int_wr_q  <= 1'b0;
            rd_pend_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // host bus answer
   // ------------------------------------------------------------
   // read data, drive enable and acknowledge are registered so the pins never glitch
   always @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         dout_q  <= 8'h00;
         doe_q   <= 1'b0;
         ack_n_q <= 1'b1;
      end else begin
         doe_q <= active & ~is_write;
         if (fetch) begin
            case (A_I)
               `IMA_OFS_DATA_LOW:  dout_q <= dout_q;  // low byte follows the answer
               `IMA_OFS_DATA_MID:  dout_q <= data_mid_q;
               `IMA_OFS_DATA_HIGH: dout_q <= data_high_q;
               `IMA_OFS_MAP_SEL:   dout_q <= map_sel_q;
               `IMA_OFS_CHAN_ADDR: dout_q <= chan_addr_q;
               `IMA_OFS_ACC_CTRL:  dout_q <= acc_ctrl_q;
               default:            dout_q <= 8'h00;
            endcase
         end else if (finish && rd_pend_q) begin
            dout_q <= INT_RDATA_I[7:0];
         end
         // strobe pair mode pulls the acknowledge low at the start and frees it when
         // the internal cycle is done; direction mode pulls it low only on completion
         // and frees it once the host has let go of the data strobe
         if (start) begin
            ack_n_q <= MODE_I;
         end else if (finish) begin
            ack_n_q <= ~MODE_I;
         end else if (state_q == ST_HOLD && !active) begin
            ack_n_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign D_O         = dout_q;
   assign D_OE_O      = doe_q;
   assign ACK_N_O     = ack_n_q;
   assign INT_ADDR_O  = {acc_ctrl_q[1:0], chan_addr_q};
   assign INT_CHAN_O  = acc_ctrl_q[7:2];
   assign INT_MAP_O   = map_sel_q[`IMA_MAP_SEL_BIT];
   assign INT_WDATA_O = {data_high_q[`IMA_HIGH_DATA_BITS-1:0], data_mid_q, data_low_q};
   assign INT_WR_O    = int_wr_q;
   assign INT_RD_O    = int_rd_q;

endmodule // ima_microport

// >>> verilog/ima_defs.vh
// constants for the indirect microport access block
`ifndef IMA_DEFS_VH
`define IMA_DEFS_VH

// ------------------------------------------------------------
// external register offsets
// ------------------------------------------------------------
`define IMA_OFS_DATA_LOW   3'h0
`define IMA_OFS_DATA_MID   3'h1
`define IMA_OFS_DATA_HIGH  3'h2
`define IMA_OFS_MAP_SEL    3'h3
`define IMA_OFS_CHAN_ADDR  3'h6
`define IMA_OFS_ACC_CTRL   3'h7

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define IMA_MAP_SEL_BIT    5
`define IMA_HIGH_DATA_BITS 4
`define IMA_REG_RESET      8'h00

`endif

// >>> verilog/ima_strobe_decode.v
// strobe decoding for both host bus conventions
`timescale 1ns/10ps
module ima_strobe_decode (
   // host control pins
   input  wire cs_n_i,
   input  wire rd_n_i,
   input  wire wr_n_i,
   input  wire mode_i,
   // decoded access
   output wire active_o,
   output wire is_write_o
);
   // mode low: separate read and store strobes; mode high: data strobe plus direction
   assign active_o   = ~cs_n_i & (mode_i ? ~rd_n_i : (~rd_n_i | ~wr_n_i));
   assign is_write_o = mode_i ? ~wr_n_i : ~wr_n_i;
endmodule // ima_strobe_decode

// >>> sim/ima_microport_monitor.sv
// assertion checker for the microport ports
`timescale 1ns/10ps
module ima_microport_monitor #(parameter DATA_W = 20) (
   // clock, reset and host pins
   input wire              CLK_I,
   input wire              RESETN_I,
   input wire              RD_N_I,
   input wire              MODE_I,
   input wire              ACK_N_O,
   input wire              D_OE_O,
   // internal side
   input wire [9:0]        INT_ADDR_O,
   input wire [DATA_W-1:0] INT_WDATA_O,
   input wire              INT_WR_O,
   input wire              INT_RD_O,
   input wire              INT_DONE_I
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);
   chk_wr_held: assert property (INT_WR_O && !INT_DONE_I |=> INT_WR_O)
      else $error("write request dropped");
   chk_wr_end: assert property (INT_WR_O && INT_DONE_I |=> !INT_WR_O)
      else $error("write request stuck");
   chk_wr_stable: assert property (INT_WR_O |=> $stable(INT_WDATA_O) && $stable(INT_ADDR_O))
      else $error("write data moved");
   chk_rd_pulse: assert property (INT_RD_O |=> !INT_RD_O)
      else $error("read pulse too long");
   chk_rd_drive: assert property (INT_RD_O |-> D_OE_O)
      else $error("no bus drive on read");
   chk_pair_ack: assert property (!MODE_I && INT_WR_O |-> !ACK_N_O)
      else $error("pair ack high in cycle");
   chk_dir_ack: assert property (MODE_I && INT_WR_O |-> ACK_N_O)
      else $error("direction ack early");
   chk_ack_free: assert property (MODE_I && !ACK_N_O && RD_N_I |=> ACK_N_O)
      else $error("ack not released");
endmodule // ima_microport_monitor
bind ima_microport ima_microport_monitor #(.DATA_W(DATA_W)) ima_microport_monitor_inst (
   .CLK_I       (CLK_I),
   .RESETN_I    (RESETN_I),
   .RD_N_I      (RD_N_I),
   .MODE_I      (MODE_I),
   .ACK_N_O     (ACK_N_O),
   .D_OE_O      (D_OE_O),
   .INT_ADDR_O  (INT_ADDR_O),
   .INT_WDATA_O (INT_WDATA_O),
   .INT_WR_O    (INT_WR_O),
   .INT_RD_O    (INT_RD_O),
   .INT_DONE_I  (INT_DONE_I)
);

// >>> sim/ima_int_space_model.sv
// model of the internal register space
`timescale 1ns/10ps
module ima_int_space_model (
   // clock, reset, answer delay
   input  wire        clk_i,
   input  wire        resetn_i,
   input  wire [2:0]  dly_i,
   // request side
   input  wire [16:0] key_i,
   input  wire [19:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output wire [19:0] rdata_o,
   output reg         done_o
);
   // no reset: a read of a location never written shows unknown to the bench
   reg [19:0] mem [0:131071];
   reg [19:0] rdata_q;
   reg [2:0]  cnt_q;
   reg        busy_q, wr_q;
   // read bus only valid in the done cycle
   assign rdata_o = done_o ? rdata_q : ~rdata_q;
   // answer each request dly_i + 1 cycles after taking it
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         done_o <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (busy_q && cnt_q == 3'h0) begin
            done_o <= 1'b1;
            busy_q <= 1'b0;
            if (wr_q) mem[key_i] <= wdata_i;
            rdata_q <= mem[key_i];
         end else if (busy_q) cnt_q <= cnt_q - 3'h1;
         else if ((wr_i && !done_o) || rd_i) begin
            busy_q <= 1'b1;
            cnt_q <= dly_i;
            wr_q <= wr_i;
         end
      end
   end
endmodule // ima_int_space_model

// >>> sim/testbench.sv
// self-checking bench for the microport block
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; $display("mismatch t=%0t %h %h", $time, g, e); end end
module testbench;
   reg         CLK_I = 0, RESETN_I = 0, CS_N_I = 1, RD_N_I = 1, WR_N_I = 1, MODE_I = 0;
   reg  [2:0]  A_I = 0, dly = 0;
   reg  [7:0]  D_I = 0, q, access_control, channel_address;
   reg  [19:0] d;
   wire [7:0]  D_O;
   wire        D_OE_O, ACK_N_O, INT_WR_O, INT_RD_O, INT_MAP_O, INT_DONE_I;
   wire [9:0]  INT_ADDR_O;
   wire [5:0]  INT_CHAN_O;
   wire [19:0] INT_WDATA_O, INT_RDATA_I;
   int         failures = 0, n_tests = 0, cyc = 0, i, k, m;
   always #50 CLK_I = ~CLK_I;
   ima_microport ima_microport_inst (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .CS_N_I(CS_N_I), .RD_N_I(RD_N_I),
      .WR_N_I(WR_N_I), .MODE_I(MODE_I), .A_I(A_I), .D_I(D_I), .D_O(D_O), .D_OE_O(D_OE_O), .ACK_N_O(ACK_N_O),
      .INT_ADDR_O(INT_ADDR_O), .INT_CHAN_O(INT_CHAN_O), .INT_MAP_O(INT_MAP_O), .INT_WDATA_O(INT_WDATA_O),
      .INT_WR_O(INT_WR_O), .INT_RD_O(INT_RD_O), .INT_RDATA_I(INT_RDATA_I), .INT_DONE_I(INT_DONE_I));
   ima_int_space_model ima_int_space_model_inst (.clk_i(CLK_I), .resetn_i(RESETN_I), .dly_i(dly),
      .key_i({INT_MAP_O, INT_CHAN_O, INT_ADDR_O}), .wdata_i(INT_WDATA_O), .wr_i(INT_WR_O),
      .rd_i(INT_RD_O), .rdata_o(INT_RDATA_I), .done_o(INT_DONE_I));
   // byte k of a 20-bit word
   function [7:0] byte_of(input [19:0] v, input int k);
      byte_of = v >> (8 * k);
   endfunction
   // one host access, strobe held until the acknowledge completes
   task automatic acc(input bit w, input [2:0] a, input [7:0] dat);
      int n = 0;
      @(negedge CLK_I);
      A_I = a;
      D_I = dat;
      CS_N_I = 1'b0;
      WR_N_I = !w;
      RD_N_I = MODE_I ? 1'b0 : w;
      while (ACK_N_O !== 1'b0 && n < 60) begin @(negedge CLK_I); n++; end
      while (!MODE_I && ACK_N_O !== 1'b1 && n < 60) begin @(negedge CLK_I); n++; end
      `CHK(n < 60, 1'b1)
      q = D_O;
      RD_N_I = 1'b1;
      WR_N_I = 1'b1;
      repeat (2) @(negedge CLK_I);
   endtask
   task complete_run;
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // hang guard
   always @(posedge CLK_I) begin
      cyc++;
      if (cyc == 6000) begin failures++; complete_run; end
   end
   // both strap modes, random internal accesses
   initial begin
      i = $urandom(32'h9AB2);
      for (m = 0; m < 2; m++) begin
         RESETN_I = 0;
         MODE_I = m[0];
         repeat (6) @(negedge CLK_I);
         RESETN_I = 1;
         for (i = 0; i < 8; i++) begin
            d = (i == 0) ? 20'hFFFFF : $urandom;
            access_control = $urandom;
            channel_address = $urandom;
            dly = $urandom % 5;
            acc(1, 3'h3, {2'h0, i[0], 5'h0});
            acc(1, 3'h6, channel_address);
            acc(1, 3'h7, access_control);
            `CHK(INT_ADDR_O, {access_control[1:0], channel_address})
            `CHK(INT_CHAN_O, access_control[7:2])
            `CHK(INT_MAP_O, i[0])
            // a store with select high must leave the registers alone
            @(negedge CLK_I);
            CS_N_I = 1'b1;
            A_I = 3'h7;
            D_I = ~access_control;
            WR_N_I = 1'b0;
            RD_N_I = !MODE_I;
            repeat (3) @(negedge CLK_I);
            WR_N_I = 1'b1;
            RD_N_I = 1'b1;
            @(negedge CLK_I);
            CS_N_I = 1'b0;
            `CHK(INT_CHAN_O, access_control[7:2])
            `CHK(ACK_N_O, 1'b1)
            for (k = 2; k >= 0; k--) acc(1, k[2:0], byte_of(d, k));
            acc(1, 3'h4, 8'hA5);
            acc(0, 3'h4, 8'h00);
            `CHK(q, 8'h00)
            acc(0, 3'h7, 8'h00);
            `CHK(q, access_control)
            for (k = 0; k < 3; k++) begin
               acc(0, k[2:0], 8'h00);
               `CHK(q & (k == 2 ? 8'h0F : 8'hFF), byte_of(d, k))
            end
            // a new low byte alone reuses the held upper bytes
            acc(1, 3'h0, ~d[7:0]);
            acc(0, 3'h0, 8'h00);
            `CHK(q, ~d[7:0])
            acc(0, 3'h1, 8'h00);
            `CHK(q, d[15:8])
         end
      end
      complete_run;
   end
endmodule // testbench
